// ### design/rcs_pkg.sv
// package for the reset and clock sequencer: register map, field layout, timing
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
package rcs_pkg;
  localparam int unsigned CLK_MHZ            = 200;
  localparam logic [7:0]  ADDR_TRIM_HIGH     = 8'h00;
  localparam logic [7:0]  ADDR_SYS_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_SEQ_CONFIG    = 8'h08;
  localparam logic [7:0]  ADDR_SEQ_STATUS    = 8'h0C;
  localparam logic [7:0]  TRIM_HIGH_RESET    = 8'hFF;
  localparam logic [1:0]  TRIM_LOW_RESET     = 2'h3;
  localparam int unsigned TRIM_LOW_LSB       = 5;
  localparam int unsigned TRIM_LOW_MSB       = 6;
  localparam int unsigned DELAY_SHORT        = 256;
  localparam int unsigned DELAY_LONG         = 4096;
  localparam int unsigned FETCH_CYCLES       = 2;
  localparam int unsigned PLL_STARTUP_US     = 1000;
  localparam int unsigned PLL_STARTUP_CYC    = PLL_STARTUP_US * CLK_MHZ;
  localparam int unsigned WDG_PULSE_NS       = 20000;
  localparam int unsigned WDG_PULSE_CYC      = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;
  // clock source selection, fixed by configuration
  localparam logic [1:0]  SRC_EXT_CLOCK      = 2'd0;
  localparam logic [1:0]  SRC_RESONATOR      = 2'd1;
  localparam logic [1:0]  SRC_INTERNAL_RC    = 2'd2;
  localparam logic [1:0]  SRC_DEFAULT_PIN    = 2'd3;
  typedef enum logic [1:0] {
    RCS_RUN    = 2'b00,
    RCS_ACTIVE = 2'b01,
    RCS_DELAY  = 2'b11,
    RCS_FETCH  = 2'b10
  } rcs_phase_e;
endpackage

// ### design/rcs_reset_clock_sequencer.sv
// reset sequence manager with clock-source selection and rc trim registers
// assumes a synchronous active-low reset, inputs synchronous to mclk_i, AXI4-Lite master
// How it works
// [R1] trim high register: 00h is fastest rc frequency, FFh slowest
// [R2] ten-bit trim is high register bits plus status bits 6:5
// [R3] software reloads the trim after every reset
// [R4] software tunes by binary search starting at 80h
// [R5] main clock comes from one configured source
// [R6] external clock drives oscillator input pin, second pin grounded
// [R7] unused oscillator block routes fixed port pin as external clock
// [R8] resonator oscillator keeps running during reset
// [R9] internal rc selected means both oscillator pins grounded
// [R10] pin, low-voltage and watchdog requests each start a reset
// [R11] illegal opcode or prefix also starts a reset
// [R12] every source drives reset pin; pin held low through delay phase
// [R13] after reset the start address comes from the top two-byte vector
// [R14] sequence runs active phase, delay phase, vector fetch in order
// [R15] delay is 256 cycles for rc or external clock, 4096 for resonator
// [R16] vector fetch lasts exactly two cycles
// [R17] enabled pll adds a startup delay on top of the count
// [R18] reset pin is open-drain, device only ever pulls it low
// [R19] low on reset pin is caught without a running clock; the code samples the pin on mclk_i only
// [R20] board holds reset low while program memory is blank
// [R21] every reset returns trim high register to all ones
// [R22] watchdog underflow drives reset pin low for a minimum pulse
// [R23] a new request during delay or fetch restarts the sequence
// [R24] internal reset release is synchronised to the selected clock
module rcs_reset_clock_sequencer
  import rcs_pkg::*;
#(
  parameter int unsigned PLL_STARTUP = PLL_STARTUP_CYC
)(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // configuration options
  input  wire logic [1:0]  clk_source_i,
  input  wire logic        pll_enable_i,
  // reset requests
  input  wire logic        reset_pin_n_i,
  input  wire logic        low_voltage_detector_i,
  input  wire logic        watchdog_underflow_i,
  input  wire logic        illegal_opcode_i,
  // reset pin drive, open drain
  output logic             reset_pin_o,
  output logic             reset_pin_oe_o,
  // core side
  output logic             core_reset_n_o,
  output logic             vector_fetch_o,
  output logic             vector_addr_lsb_o,
  output logic [9:0]       rc_trim_o,
  output logic             resonator_run_o,
  output logic             use_default_ext_pin_o,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  localparam int unsigned CW = $clog2(DELAY_LONG + PLL_STARTUP + 1);

  if (PLL_STARTUP < 1 || CW > 31)
  begin
    $error("PLL_STARTUP out of range");
  end

  rcs_phase_e      phase_reg;
  logic [CW-1:0]   count_reg;
  logic [7:0]      trim_high_reg;
  logic [1:0]      trim_low_reg;
  logic [15:0]     wdg_cnt_reg;
  logic            wdg_seen_reg;
  logic            lvd_seen_reg;
  logic            aw_got_reg;
  logic            w_got_reg;
  logic [7:0]      aw_addr_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;
  logic            seq_reset;
  logic            request;
  logic [CW-1:0]   delay_load;

  // the pin is taken as a level and sampled on mclk_i; the reset port is synchronous too;
  // our own pull reads back low, so it is masked or the sequence would never end
  assign request = (!reset_pin_n_i && !reset_pin_oe_o) || low_voltage_detector_i
                   || watchdog_underflow_i || illegal_opcode_i; // R10 R11 R19
  assign seq_reset = !rst_n_i || phase_reg != RCS_RUN;

  always_comb
  begin
    delay_load = (clk_source_i == SRC_RESONATOR) ? CW'(DELAY_LONG) : CW'(DELAY_SHORT); // R15
    if (pll_enable_i)
      delay_load = delay_load + CW'(PLL_STARTUP); // R17
  end

  // sequencer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      phase_reg <= RCS_ACTIVE;
      count_reg <= '0;
    end
    else if (request)
    begin
      phase_reg <= RCS_ACTIVE; // R23
      count_reg <= '0;
    end
    else
    begin
      unique case (phase_reg)
        RCS_ACTIVE:
        begin
          phase_reg <= RCS_DELAY; // R14 R24
          count_reg <= delay_load - CW'(1);
        end
        RCS_DELAY:
        begin
          if (count_reg == '0)
          begin
            phase_reg <= RCS_FETCH;
            count_reg <= CW'(FETCH_CYCLES - 1); // R16
          end
          else
            count_reg <= count_reg - CW'(1);
        end
        RCS_FETCH:
        begin
          if (count_reg == '0)
            phase_reg <= RCS_RUN;
          else
            count_reg <= count_reg - CW'(1);
        end
        RCS_RUN:
        begin
          count_reg <= '0;
        end
      endcase
    end
  end

  // watchdog pulse stretcher keeps the pin low for the minimum width
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      wdg_cnt_reg <= '0;
    else if (watchdog_underflow_i)
      wdg_cnt_reg <= 16'(WDG_PULSE_CYC); // R22
    else if (wdg_cnt_reg != '0)
      wdg_cnt_reg <= wdg_cnt_reg - 16'h0001;
  end

  // outputs toward pin and core
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      reset_pin_oe_o    <= 1'b1;
      reset_pin_o       <= 1'b0;
      core_reset_n_o    <= 1'b0;
      vector_fetch_o    <= 1'b0;
      vector_addr_lsb_o <= 1'b0;
    end
    else
    begin
      reset_pin_o       <= 1'b0; // R18
      reset_pin_oe_o    <= request || phase_reg == RCS_ACTIVE || phase_reg == RCS_DELAY
                           || wdg_cnt_reg != '0; // R12 R22
      core_reset_n_o    <= !request && phase_reg == RCS_RUN;
      vector_fetch_o    <= !request && phase_reg == RCS_FETCH; // R13
      // lsb 0 then 1 selects the high and low vector bytes in turn
      vector_addr_lsb_o <= !request && phase_reg == RCS_FETCH && count_reg == '0;
    end
  end

  // clock routing: resonator never stopped by reset
  always_ff @(posedge mclk_i)
  begin
    resonator_run_o       <= clk_source_i == SRC_RESONATOR; // R5 R8
    use_default_ext_pin_o <= clk_source_i == SRC_DEFAULT_PIN; // R7
  end

  // register bus write path
  logic do_write;
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == ADDR_TRIM_HIGH || aw_addr_reg == ADDR_SYS_STATUS
                         || aw_addr_reg == ADDR_SEQ_CONFIG || aw_addr_reg == ADDR_SEQ_STATUS)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // trim registers return to slowest setting on any reset
  always_ff @(posedge mclk_i)
  begin
    if (seq_reset)
    begin
      trim_high_reg <= TRIM_HIGH_RESET; // R21
      trim_low_reg  <= TRIM_LOW_RESET;
    end
    else if (do_write && w_strb_reg[0])
    begin
      if (aw_addr_reg == ADDR_TRIM_HIGH)
        trim_high_reg <= w_data_reg[7:0]; // R1
      if (aw_addr_reg == ADDR_SYS_STATUS)
        trim_low_reg <= w_data_reg[TRIM_LOW_MSB:TRIM_LOW_LSB]; // R2
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rc_trim_o <= {TRIM_HIGH_RESET, TRIM_LOW_RESET};
    else
      rc_trim_o <= {trim_high_reg, trim_low_reg}; // R2
  end

  // cause flags survive the sequence so software can see watchdog and low-voltage causes
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wdg_seen_reg <= 1'b0;
      lvd_seen_reg <= 1'b0;
    end
    else
    begin
      if (watchdog_underflow_i)
        wdg_seen_reg <= 1'b1;
      else if (do_write && aw_addr_reg == ADDR_SEQ_STATUS)
        wdg_seen_reg <= 1'b0;
      if (low_voltage_detector_i)
        lvd_seen_reg <= 1'b1;
      else if (do_write && aw_addr_reg == ADDR_SEQ_STATUS)
        lvd_seen_reg <= 1'b0;
    end
  end

  // register bus read path, one cycle answer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      unique case (s_axi_araddr)
        ADDR_TRIM_HIGH:  s_axi_rdata <= {24'h0000_00, trim_high_reg};
        ADDR_SYS_STATUS: s_axi_rdata <= {25'h000_0000, trim_low_reg, 5'h00};
        ADDR_SEQ_CONFIG: s_axi_rdata <= {29'h0000_0000, pll_enable_i, clk_source_i};
        ADDR_SEQ_STATUS: s_axi_rdata <= {28'h000_0000, lvd_seen_reg, wdg_seen_reg,
                                         phase_reg};
        default:         s_axi_rresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // assertions
  sequence s_fetch_two;
    vector_fetch_o && !vector_addr_lsb_o ##1 vector_fetch_o && vector_addr_lsb_o;
  endsequence

  a_request_restarts: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R23
    request |=> phase_reg == RCS_ACTIVE)
    else $error("request did not restart the sequence");
  a_pin_held_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
    phase_reg == RCS_DELAY |=> reset_pin_oe_o && !reset_pin_o)
    else $error("reset pin released during delay");
  a_fetch_two_cycles: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R16
    $rose(vector_fetch_o) |-> s_fetch_two ##1 !vector_fetch_o)
    else $error("vector fetch not two cycles");
  a_short_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R15
    phase_reg == RCS_ACTIVE && !request && clk_source_i != SRC_RESONATOR && !pll_enable_i
    |=> count_reg == CW'(DELAY_SHORT - 1))
    else $error("short delay load wrong");
  a_long_delay: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R15
    phase_reg == RCS_ACTIVE && !request && clk_source_i == SRC_RESONATOR && !pll_enable_i
    |=> count_reg == CW'(DELAY_LONG - 1))
    else $error("long delay load wrong");
  a_pll_extra: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R17
    phase_reg == RCS_ACTIVE && !request && pll_enable_i
    |=> count_reg > CW'(DELAY_SHORT - 1))
    else $error("pll delay missing");
  a_trim_resets: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R21
    phase_reg == RCS_ACTIVE |=> trim_high_reg == TRIM_HIGH_RESET)
    else $error("trim not reset");
  a_pin_low_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
    reset_pin_oe_o |-> !reset_pin_o)
    else $error("reset pin driven high");
  a_phase_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
    phase_reg == RCS_RUN && !$stable(phase_reg) |-> $past(phase_reg) == RCS_FETCH)
    else $error("run entered out of order");
  a_wdg_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
    watchdog_underflow_i |=> reset_pin_oe_o [*4])
    else $error("watchdog pulse too short");
endmodule

// ### testbench/rcs_board_model.sv
// board around the reset pin: weak pull-up, external reset button and power-up hold
// assumes the device reaches the pin only through its open-drain enable
module rcs_board_model (
  // device side
  input  wire logic oe_i,
  input  wire logic drv_i,
  // board side
  input  wire logic hold_i,
  input  wire logic pull_i,
  output logic      pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired-and: any party pulling low beats the pull-up, nobody ever drives it high
  assign pin_n_o = !((oe_i && !drv_i) || hold_i || pull_i);
endmodule

// ### testbench/rcs_reset_clock_sequencer_tb.sv
// self-checking bench for the reset and clock sequencer
// assumes the hand-over timing of the design; pll startup shortened to 8 cycles
module rcs_reset_clock_sequencer_tb;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PSU = 8;
  logic        mclk_i = 0;
  logic        rst_n_i = 0;
  logic [1:0]  src = 0;
  logic        pll = 0;
  logic [3:0]  req = 0;
  logic        hold = 1;
  logic        pin_n, oe, pin_o, core_n, fetch, lsb, res_run, def_pin;
  logic [9:0]  trim, tr_q;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [33:0] exp_q[$];
  logic [9:0]  tq[$];
  logic [9:0]  cur = 10'h3FF;
  logic        quiet = 1, wdg_chk = 0, oe_q = 0, fe_q = 0;
  logic [15:0] cnt = 0, ol = 0;
  logic [7:0]  fl = 0;
  logic [1:0]  lsbs = 0;

  always #2.5 mclk_i = ~mclk_i;

  rcs_board_model i_board (.oe_i(oe), .drv_i(pin_o), .hold_i(hold), .pull_i(req[0]),
    .pin_n_o(pin_n));
  rcs_reset_clock_sequencer #(.PLL_STARTUP(PSU)) i_dut (.mclk_i, .rst_n_i,
    .clk_source_i(src), .pll_enable_i(pll), .reset_pin_n_i(pin_n),
    .low_voltage_detector_i(req[1]), .watchdog_underflow_i(req[2]),
    .illegal_opcode_i(req[3]), .reset_pin_o(pin_o), .reset_pin_oe_o(oe),
    .core_reset_n_o(core_n), .vector_fetch_o(fetch), .vector_addr_lsb_o(lsb),
    .rc_trim_o(trim), .resonator_run_o(res_run), .use_default_ext_pin_o(def_pin),
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // monitor: every bus, fetch or trim result that shows up takes the oldest note off its queue
  always @(posedge mclk_i)
  begin
    oe_q <= oe;
    fe_q <= fetch;
    tr_q <= trim;
    cnt  <= (oe && !oe_q) ? 16'h0 : cnt + 16'h1;
    ol   <= oe ? ol + 16'h1 : 16'h0;
    if (oe && !oe_q)
    begin
      fl   <= 8'h0;
      lsbs <= 2'h0;
    end
    else if (fetch)
    begin
      fl   <= fl + 8'h1;
      lsbs <= {lsbs[0], lsb};
    end
    if (oe)
      chk(34'(pin_o), 34'h0);
    if (!quiet)
    begin
      if (s_axi_rvalid && s_axi_rready)
        chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
        chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (fetch && !fe_q)
        chk({16'h0, res_run, def_pin, cnt}, exp_q.pop_front());
      if (!fetch && fe_q)
        chk({23'h0, core_n, lsbs, fl}, exp_q.pop_front());
      if (trim !== tr_q)
        chk(34'(trim), 34'(tq.pop_front()));
      if (!oe && oe_q && wdg_chk)
        chk(34'(ol >= WDG_PULSE_CYC), 34'h1);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah;
    logic wh;
    exp_q.push_back({r, 32'h0});
    @(posedge mclk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(negedge mclk_i);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      @(posedge mclk_i);
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    do @(negedge mclk_i); while (!s_axi_bvalid);
    @(posedge mclk_i);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(negedge mclk_i); while (!s_axi_arready);
    @(posedge mclk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk_i); while (!s_axi_rvalid);
    @(posedge mclk_i);
    s_axi_rready <= 1'b0;
  endtask

  // load both trim parts, expecting the output to move only when a value changes
  task automatic ld(input logic [7:0] h, input logic [1:0] l);
    if ({h, cur[1:0]} !== cur)
      tq.push_back({h, cur[1:0]});
    wr(ADDR_TRIM_HIGH, {24'h0, h}, RESP_OKAY);
    cur = {h, cur[1:0]};
    if (cur[1:0] !== l)
      tq.push_back({h, l});
    wr(ADDR_SYS_STATUS, 32'(l) << TRIM_LOW_LSB, RESP_OKAY);
    cur = {h, l};
    rd(ADDR_TRIM_HIGH, {24'h0, h}, RESP_OKAY);
    rd(ADDR_SYS_STATUS, 32'(l) << TRIM_LOW_LSB, RESP_OKAY);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk_i);
    req <= 4'(1 << k);
    @(posedge mclk_i);
    req <= 4'h0;
  endtask

  // k picks the request: pin, low voltage, watchdog, illegal opcode; gap > 0 restarts
  task automatic seq(input logic [1:0] s, input logic p, input int k, input int gap);
    int n;
    // the edge count starts with the pin drive, one edge after the request
    n = (s == SRC_RESONATOR ? DELAY_LONG : DELAY_SHORT) + (p ? PSU : 0) + 1 + gap;
    @(posedge mclk_i);
    src <= s;
    pll <= p;
    if (cur !== 10'h3FF)
      tq.push_back(10'h3FF);
    cur = 10'h3FF;
    exp_q.push_back({16'h0, s == SRC_RESONATOR, s == SRC_DEFAULT_PIN, 16'(n)});
    exp_q.push_back({23'h0, 1'b1, 2'b01, 8'h2});
    wdg_chk = (k == 2);
    pulse(k);
    if (gap > 0)
    begin
      repeat (gap - 2) @(posedge mclk_i);
      pulse(3);
    end
    do @(negedge mclk_i); while (!core_n || oe);
    // the monitor sees the release one edge later
    @(negedge mclk_i);
    wdg_chk = 0;
  endtask

  initial
  begin
    void'($urandom(32'hE609));
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    hold <= 1'b0;
    do @(negedge mclk_i); while (!core_n || oe);
    @(posedge mclk_i);
    quiet <= 1'b0;
    rd(ADDR_TRIM_HIGH, 32'h0000_00FF, RESP_OKAY);
    rd(ADDR_SYS_STATUS, 32'h0000_0060, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h0, RESP_SLVERR);
    @(posedge mclk_i);
    s_axi_wstrb <= 4'hE;
    wr(ADDR_TRIM_HIGH, 32'h0000_0012, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_TRIM_HIGH, 32'h0000_00FF, RESP_OKAY);
    ld(8'h80, 2'h2);
    ld(8'h00, 2'h0);
    ld(8'hFF, 2'h3);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      seq(2'(i), i[2], (i + i / 4) % 4, 0);
      rd(ADDR_SEQ_CONFIG, {29'h0, i[2], 2'(i)}, RESP_OKAY);
      ld(8'($urandom), 2'($urandom));
    end
    rd(ADDR_SEQ_STATUS, 32'h0000_000C, RESP_OKAY);
    wr(ADDR_SEQ_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_SEQ_STATUS, 32'h0, RESP_OKAY);
    $display("test sources done");
    seq(SRC_EXT_CLOCK, 1'b0, 1, 100);
    rd(ADDR_SEQ_STATUS, 32'h0000_0008, RESP_OKAY);
    $display("test restart done");
    close_out();
  end

  // the whole run needs about 14400 cycles; over three times that means a hang
  initial
  begin
    repeat (50000) @(posedge mclk_i);
    error_cnt++;
    close_out();
  end
endmodule
